// >>> core/pulse_input_interrupt_unit.sv
// pulse input interrupt unit: quick inputs, interrupt inputs, scan sequencer
// Function
// R1: quick input pulse shorter than a scan is held in its status bit one scan
// R2: any high pulse of 30 us or longer is captured
// R3: captured status is cleared at the following I/O refresh
// R4: module 0 status in word 2960 bits 0-3, module 1 in word 2962 bits 0-3
// R5: scan repeats housekeeping, execution, I/O refresh, peripheral servicing
// R6: interrupt suspends cyclic program, runs task to end, then resumes it
// R7: direct mode starts task on selected rising or falling edge
// R8: counter mode fires at set value counting up, at zero counting down
// R9: inputs bound to fixed task numbers 140 to 147
// R10: eight interrupt inputs, bits 0-3 of one word per module
// R11: counter set value is 16 bits, 0001 to FFFF, one word per input
// R12: counting direction chosen by the mask command, latest command wins
// R13: all eight counters track edges up to 3 kHz together
// R14: present count of each counter input published in its own word
// R15: configuration gives each terminal exactly one function
// R16: each input synchronised before edge detection
`timescale 1ns/1ns
`include "pulse_input_consts.svh"
module pulse_input_interrupt_unit #(
    parameter int N_INPUTS = 8
) (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    // field inputs
    input  wire logic                   module0_input_a,
    input  wire logic                   module0_input_b,
    input  wire logic                   module0_input_c,
    input  wire logic                   module0_input_d,
    input  wire logic                   module1_input_a,
    input  wire logic                   module1_input_b,
    input  wire logic                   module1_input_c,
    input  wire logic                   module1_input_d,
    // stored configuration, applied at run start
    input  wire pulse_input_pkg::mode_t cfg_mode [N_INPUTS],
    input  wire logic [N_INPUTS-1:0]    cfg_falling,
    input  wire logic                   run_start,
    // interrupt mask command
    input  wire logic                   interrupt_mask_command,
    input  wire logic [2:0]             mask_index,
    input  wire logic                   mask_enable,
    input  wire logic                   mask_falling,
    input  wire logic                   mask_count_down,
    // set value words
    input  wire logic                   sv_write,
    input  wire logic [2:0]             sv_index,
    input  wire logic [15:0]            sv_data,
    // scan sequencing
    input  wire logic                   phase_done,
    input  wire logic                   task_done,
    output      pulse_input_pkg::phase_t scan_phase,
    output      logic                   cyclic_run,
    // interrupt task request
    output      logic                   task_start,
    output      logic                   task_active,
    output      logic [7:0]             task_number,
    // bit read port
    input  wire logic [15:0]            bit_load_addr,
    input  wire logic [3:0]             bit_load_bit,
    output      logic                   bit_load_data,
    // present counts and set values
    output      logic [N_INPUTS-1:0][15:0] present_count,
    output      logic [N_INPUTS-1:0][15:0] set_value_word
);
    import pulse_input_pkg::*;

    logic [N_INPUTS-1:0] pins;
    logic [N_INPUTS-1:0] status;
    logic [N_INPUTS-1:0] pending;
    logic [N_INPUTS-1:0] taken;
    logic                refresh;

    // scan phase
    phase_t phase_q, phase_d;

    // per input control
    logic [N_INPUTS-1:0] falling_q, falling_d;
    logic [N_INPUTS-1:0] enable_q, enable_d;
    logic [N_INPUTS-1:0] down_q, down_d;
    logic [N_INPUTS-1:0] reload_q, reload_d;
    mode_t               mode_q [N_INPUTS];
    mode_t               mode_d [N_INPUTS];

    // set values
    logic [N_INPUTS-1:0][15:0] sv_q, sv_d;

    // task sequencing
    logic       active_q, active_d;
    logic       start_q, start_d;
    logic [7:0] num_q, num_d;

    // bit read
    logic       rd_q, rd_d;

    assign pins = {module1_input_d, module1_input_c, module1_input_b, module1_input_a,
                   module0_input_d, module0_input_c, module0_input_b, module0_input_a}; // R10

    always_comb begin
        phase_d = phase_q;
        if (phase_done) begin
            case (phase_q) // R5
                PH_HOUSEKEEP:  phase_d = PH_EXECUTE;
                PH_EXECUTE:    phase_d = PH_REFRESH;
                PH_REFRESH:    phase_d = PH_PERIPHERAL;
                PH_PERIPHERAL: phase_d = PH_HOUSEKEEP;
                default:       phase_d = PH_HOUSEKEEP;
            endcase
        end
    end

    // one-cycle strobe on entry to the refresh phase
    assign refresh = phase_done && (phase_q == PH_EXECUTE); // R3

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            phase_q <= PH_HOUSEKEEP;
        end else begin
            phase_q <= phase_d;
        end
    end

    always_comb begin
        falling_d = falling_q;
        enable_d  = enable_q;
        down_d    = down_q;
        mode_d    = mode_q;
        reload_d  = '0;
        if (run_start) begin
            // stored settings take effect only on entry to run
            falling_d = cfg_falling; // R7
            enable_d  = '0;
            mode_d    = cfg_mode; // R15
            reload_d  = '1;
        end else if (interrupt_mask_command) begin
            falling_d[mask_index] = mask_falling; // R7
            enable_d[mask_index]  = mask_enable;
            down_d[mask_index]    = mask_count_down; // R12
            reload_d[mask_index]  = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            falling_q <= '0;
            enable_q  <= '0;
            down_q    <= '0;
            reload_q  <= '0;
            mode_q    <= '{default: MODE_NORMAL};
        end else begin
            falling_q <= falling_d;
            enable_q  <= enable_d;
            down_q    <= down_d;
            reload_q  <= reload_d;
            mode_q    <= mode_d;
        end
    end

    always_comb begin
        sv_d = sv_q;
        // zero is outside the counting range, so such a write is dropped
        if (sv_write && sv_data != `SV_ZERO) begin
            sv_d[sv_index] = sv_data; // R11
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sv_q <= '{default: `SV_RESET};
        end else begin
            sv_q <= sv_d;
        end
    end

    always_comb begin
        active_d = active_q;
        start_d  = 1'b0;
        num_d    = num_q;
        taken    = '0;
        if (active_q) begin
            // tasks do not nest; later events wait as pending
            if (task_done) begin
                active_d = 1'b0; // R6
            end
        end else begin
            for (int i = N_INPUTS - 1; i >= 0; i--) begin
                if (pending[i]) begin
                    taken    = '0;
                    taken[i] = 1'b1;
                    num_d    = 8'(`TASK_BASE + 8'(i)); // R9
                end
            end
            if (|pending) begin
                active_d = 1'b1; // R6
                start_d  = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            active_q <= 1'b0;
            start_q  <= 1'b0;
            num_q    <= `TASK_BASE;
        end else begin
            active_q <= active_d;
            start_q  <= start_d;
            num_q    <= num_d;
        end
    end

    always_comb begin
        rd_d = 1'b0;
        if (bit_load_bit < 4'(`QR_BITS_PER_MOD)) begin
            if (bit_load_addr == `QR_WORD0_ADDR) begin
                rd_d = status[bit_load_bit[1:0]]; // R4
            end else if (bit_load_addr == `QR_WORD1_ADDR) begin
                rd_d = status[`QR_BITS_PER_MOD + 32'(bit_load_bit[1:0])]; // R4
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rd_q <= 1'b0;
        end else begin
            rd_q <= rd_d;
        end
    end

    // channels run in parallel, one edge per clock each, far above 3 kHz
    for (genvar g = 0; g < N_INPUTS; g++) begin : g_chan
        chan_if ch ();
        assign ch.mode       = mode_q[g];
        assign ch.falling    = falling_q[g];
        assign ch.enable     = enable_q[g];
        assign ch.count_down = down_q[g];
        assign ch.set_value  = sv_q[g];
        assign ch.reload     = reload_q[g];
        assign ch.refresh    = refresh;
        assign ch.taken      = taken[g];
        assign status[g]     = ch.status;
        assign pending[g]    = ch.pending;
        assign present_count[g] = ch.count; // R14
        input_channel u_chan ( // R13
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .pin      (pins[g]),
            .ch       (ch)
        );
    end

    assign scan_phase     = phase_q;
    assign cyclic_run     = (phase_q == PH_EXECUTE) && !active_q; // R6
    assign task_start     = start_q;
    assign task_active    = active_q;
    assign task_number    = num_q;
    assign bit_load_data  = rd_q;
    assign set_value_word = sv_q;
endmodule

// >>> core/pulse_input_consts.svh
// constants of the pulse input interrupt unit
`ifndef PULSE_INPUT_CONSTS_SVH
`define PULSE_INPUT_CONSTS_SVH
`define QR_WORD0_ADDR   16'hB90
`define QR_WORD1_ADDR   16'hB92
`define QR_BITS_PER_MOD 4
`define TASK_BASE       8'h8C
`define SV_RESET        16'h0001
`define SV_ZERO         16'h0000
`define CLK_PERIOD_NS   8
`define QR_MIN_ON_NS    30000
`define QR_MIN_ON_CYC   ((`QR_MIN_ON_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> core/pulse_input_pkg.sv
// types of the pulse input interrupt unit
package pulse_input_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_QUICK,
        MODE_DIRECT,
        MODE_COUNTER
    } mode_t;
    typedef enum logic [1:0] {
        PH_HOUSEKEEP,
        PH_EXECUTE,
        PH_REFRESH,
        PH_PERIPHERAL
    } phase_t;
endpackage

// >>> core/chan_if.sv
// carrier between the unit and one input channel
`timescale 1ns/1ns
interface chan_if;
    import pulse_input_pkg::*;
    mode_t       mode;
    logic        falling;
    logic        enable;
    logic        count_down;
    logic [15:0] set_value;
    logic        reload;
    logic        refresh;
    logic        taken;
    logic        status;
    logic        pending;
    logic [15:0] count;
    modport ctrl (output mode, falling, enable, count_down, set_value, reload, refresh, taken,
                  input status, pending, count);
    modport chan (input mode, falling, enable, count_down, set_value, reload, refresh, taken,
                  output status, pending, count);
endinterface

// >>> core/input_channel.sv
// one field input: synchroniser, capture, edge interrupt and counter
`timescale 1ns/1ns
module input_channel (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // field pin
    input wire logic pin,
    // unit side
    chan_if.chan     ch
);
    import pulse_input_pkg::*;

    logic        sync1_q, sync1_d;
    logic        sync2_q, sync2_d;
    logic        prev_q, prev_d;
    logic        cap_q, cap_d;
    logic        status_q, status_d;
    logic        pend_q, pend_d;
    logic [15:0] count_q, count_d;
    logic        hit;
    logic        fire;

    always_comb begin
        sync1_d  = pin;
        sync2_d  = sync1_q; // R16
        prev_d   = sync2_q;
        hit      = ch.falling ? (prev_q & ~sync2_q) : (~prev_q & sync2_q); // R7
        fire     = 1'b0;
        cap_d    = ch.refresh ? 1'b0 : cap_q;
        // set beats the refresh clear so a pulse at the boundary survives
        if (ch.mode == MODE_QUICK && sync2_q) begin
            cap_d = 1'b1; // R2
        end
        status_d = status_q;
        if (ch.refresh) begin
            status_d = (ch.mode == MODE_QUICK) ? (cap_q | sync2_q) : sync2_q; // R1 R3
        end
        count_d  = count_q;
        if (ch.reload) begin
            count_d = ch.count_down ? ch.set_value : `SV_ZERO; // R12
        end else if (ch.mode == MODE_COUNTER && hit) begin
            if (ch.count_down) begin
                count_d = 16'(count_q - 16'h0001); // R8
                if (count_d == `SV_ZERO) begin
                    fire    = 1'b1;
                    count_d = ch.set_value;
                end
            end else begin
                count_d = 16'(count_q + 16'h0001); // R8
                if (count_d == ch.set_value) begin
                    fire    = 1'b1;
                    count_d = `SV_ZERO;
                end
            end
        end else if (ch.mode == MODE_DIRECT && hit) begin
            fire = 1'b1; // R7
        end
        // counting goes on while disabled; only the task request is held back
        pend_d = (pend_q & ~ch.taken) | (ch.enable & fire);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1_q  <= 1'b0;
            sync2_q  <= 1'b0;
            prev_q   <= 1'b0;
            cap_q    <= 1'b0;
            status_q <= 1'b0;
            pend_q   <= 1'b0;
            count_q  <= `SV_ZERO;
        end else begin
            sync1_q  <= sync1_d;
            sync2_q  <= sync2_d;
            prev_q   <= prev_d;
            cap_q    <= cap_d;
            status_q <= status_d;
            pend_q   <= pend_d;
            count_q  <= count_d;
        end
    end

    assign ch.status  = status_q;
    assign ch.pending = pend_q;
    assign ch.count   = count_q;
endmodule

// >>> tb/pulse_input_interrupt_unit_assertions.sv
// concurrent checks on the pulse input interrupt unit ports
`timescale 1ns/1ns
module pulse_input_checker #(
    parameter int N_INPUTS = 8
) (
    // clock and reset
    input wire logic                      core_clk,
    input wire logic                      rst_n,
    // scan and task
    input wire logic                      phase_done,
    input wire logic                      task_done,
    input wire pulse_input_pkg::phase_t   scan_phase,
    input wire logic                      cyclic_run,
    input wire logic                      task_start,
    input wire logic                      task_active,
    input wire logic [7:0]                task_number,
    // set values
    input wire logic                      sv_write,
    input wire logic [2:0]                sv_index,
    input wire logic [15:0]               sv_data,
    input wire logic [N_INPUTS-1:0][15:0] set_value_word
);
    import pulse_input_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    a_phase_step: assert property (phase_done |=> scan_phase == phase_t'($past(scan_phase) + 2'h1))
        else $error("scan phase did not advance");
    a_phase_hold: assert property (!phase_done |=> $stable(scan_phase))
        else $error("scan phase moved without a step");
    a_cyclic_held: assert property (task_active |-> !cyclic_run)
        else $error("cyclic program ran during a task");
    a_start_once: assert property (task_start |-> task_active ##1 !task_start)
        else $error("task start not a single pulse");
    a_no_nesting: assert property (task_active && !task_done |=> !task_start)
        else $error("task started while another runs");
    a_done_ends: assert property (task_active && task_done |=> !task_active && !task_start)
        else $error("task did not end on done");
    a_task_range: assert property (task_start |-> task_number inside {[8'h8C:8'h93]})
        else $error("task number out of range");
    a_number_held: assert property (task_active && !task_start |-> $stable(task_number))
        else $error("task number changed mid task");
    a_sv_store: assert property (sv_write && sv_data != 16'h0000 |=>
        set_value_word[$past(sv_index)] == $past(sv_data))
        else $error("set value not stored");
    a_sv_zero: assert property (sv_write && sv_data == 16'h0000 |=> $stable(set_value_word))
        else $error("zero set value accepted");

    c_direct: cover property (task_start && task_number == 8'h91);
    c_counter: cover property (task_start && task_number == 8'h93);
    c_refresh: cover property (phase_done && scan_phase == PH_EXECUTE);
endmodule

bind pulse_input_interrupt_unit pulse_input_checker #(.N_INPUTS(N_INPUTS)) chk (
    .core_clk, .rst_n, .phase_done, .task_done, .scan_phase, .cyclic_run, .task_start,
    .task_active, .task_number, .sv_write, .sv_index, .sv_data, .set_value_word);

// >>> tb/field_source.sv
// field signal source driving the eight 24 V inputs
`timescale 1ns/1ns
module field_source (
    // clock
    input wire logic   core_clk,
    // field pins
    output logic [7:0] pin
);
    // an open input reads off, so idle is low
    initial begin
        pin = 8'h00;
    end
    // high for w cycles, changed off the sampling edge
    task automatic pulse(input int idx, input int w);
        @(negedge core_clk);
        pin[idx] = 1'b1;
        repeat (w) @(negedge core_clk);
        pin[idx] = 1'b0;
    endtask
endmodule

// >>> tb/tb_pulse_input_interrupt_unit.sv
// self-checking bench of the pulse input interrupt unit
`timescale 1ns/1ns
`include "pulse_input_consts.svh"
module tb_pulse_input_interrupt_unit;
    import pulse_input_pkg::*;
    logic             core_clk, rst_n, run_start, phase_done, task_done, sv_write;
    logic             interrupt_mask_command, mask_enable, mask_falling, mask_count_down;
    logic             cyclic_run, task_start, task_active, bit_load_data;
    logic [2:0]       mask_index, sv_index;
    logic [15:0]      sv_data, bit_load_addr;
    logic [3:0]       bit_load_bit;
    logic [7:0]       pin, cfg_falling, task_number;
    logic [7:0][15:0] present_count, set_value_word;
    mode_t            cfg_mode [8];
    phase_t           scan_phase;
    int               miscompares, checked;

    field_source fs (.core_clk(core_clk), .pin(pin));
    pulse_input_interrupt_unit dut (
        .core_clk(core_clk), .rst_n(rst_n),
        .module0_input_a(pin[0]), .module0_input_b(pin[1]), .module0_input_c(pin[2]),
        .module0_input_d(pin[3]), .module1_input_a(pin[4]), .module1_input_b(pin[5]),
        .module1_input_c(pin[6]), .module1_input_d(pin[7]),
        .cfg_mode(cfg_mode), .cfg_falling(cfg_falling), .run_start(run_start),
        .interrupt_mask_command(interrupt_mask_command), .mask_index(mask_index),
        .mask_enable(mask_enable), .mask_falling(mask_falling), .mask_count_down(mask_count_down),
        .sv_write(sv_write), .sv_index(sv_index), .sv_data(sv_data),
        .phase_done(phase_done), .task_done(task_done), .scan_phase(scan_phase),
        .cyclic_run(cyclic_run), .task_start(task_start), .task_active(task_active),
        .task_number(task_number), .bit_load_addr(bit_load_addr), .bit_load_bit(bit_load_bit),
        .bit_load_data(bit_load_data), .present_count(present_count), .set_value_word(set_value_word));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) begin
            phase_done = 1'b1;
            tick(1);
            phase_done = 1'b0;
            tick(1);
        end
    endtask
    // the reload lands two edges after the command
    task automatic cmd(input logic [2:0] idx, input logic en, input logic fall, input logic down);
        mask_index = idx;
        mask_enable = en;
        mask_falling = fall;
        mask_count_down = down;
        interrupt_mask_command = 1'b1;
        tick(1);
        interrupt_mask_command = 1'b0;
        tick(3);
    endtask
    task automatic rd(input logic [15:0] addr, input logic [3:0] b, input logic exp);
        bit_load_addr = addr;
        bit_load_bit = b;
        tick(1);
        chk({15'h0000, bit_load_data}, {15'h0000, exp});
    endtask
    task automatic wait_start(input logic [7:0] num);
        int i;
        for (i = 0; i < 64 && task_start !== 1'b1; i++) begin
            tick(1);
        end
        if (i == 64) begin
            miscompares++;
            $display("[FAIL] %0t no task start", $time);
            close_out();
        end else begin
            chk({8'h00, task_number}, {8'h00, num});
            chk({15'h0000, task_active}, 16'h0001);
            chk({15'h0000, cyclic_run}, 16'h0000);
            task_done = 1'b1;
            tick(1);
            task_done = 1'b0;
            tick(1);
        end
    endtask
    // spaced so every edge is seen on its own
    task automatic edges(input int n);
        repeat (n) begin
            fs.pulse(7, 4);
            tick(4);
        end
    endtask

    initial begin
        {rst_n, run_start, phase_done, task_done, sv_write, interrupt_mask_command} = 6'h00;
        {mask_enable, mask_falling, mask_count_down, mask_index, sv_index} = 9'h000;
        {sv_data, bit_load_addr, bit_load_bit, cfg_falling} = 44'h0;
        cfg_mode = '{default: MODE_NORMAL};
        cfg_mode[2] = MODE_QUICK;
        cfg_mode[5] = MODE_DIRECT;
        cfg_mode[7] = MODE_COUNTER;
        tick(2);
        rst_n = 1'b1;
        chk({8'h00, task_number}, {8'h00, `TASK_BASE});
        chk(set_value_word[7], `SV_RESET);
        chk({14'h0000, scan_phase}, {14'h0000, PH_HOUSEKEEP});
        run_start = 1'b1;
        tick(1);
        run_start = 1'b0;
        $display("reset test done");

        step(1);
        fs.pulse(2, `QR_MIN_ON_CYC);
        tick(4);
        step(1);
        chk({14'h0000, scan_phase}, {14'h0000, PH_REFRESH});
        rd(`QR_WORD0_ADDR, 4'h2, 1'b1);
        rd(`QR_WORD0_ADDR, 4'h3, 1'b0);
        rd(`QR_WORD1_ADDR, 4'h2, 1'b0);
        rd(16'hB91, 4'h2, 1'b0);
        step(4);
        rd(`QR_WORD0_ADDR, 4'h2, 1'b0);
        $display("quick input test done");

        step(3);
        cmd(3'h5, 1'b1, 1'b0, 1'b0);
        fs.pulse(5, 2);
        wait_start(8'h91);
        chk({15'h0000, cyclic_run}, 16'h0001);
        cmd(3'h5, 1'b1, 1'b1, 1'b0);
        fs.pulse(5, 20);
        wait_start(8'h91);
        // a disabled input must not start its task
        cmd(3'h5, 1'b0, 1'b0, 1'b0);
        fs.pulse(5, 2);
        tick(8);
        chk({15'h0000, task_active}, 16'h0000);
        $display("direct mode test done");

        sv_index = 3'h7;
        sv_data = 16'h0003;
        sv_write = 1'b1;
        tick(1);
        sv_data = 16'h0000;
        tick(1);
        sv_write = 1'b0;
        tick(1);
        chk(set_value_word[7], 16'h0003);
        cmd(3'h7, 1'b1, 1'b0, 1'b0);
        edges(2);
        chk(present_count[7], 16'h0002);
        fs.pulse(7, 2);
        wait_start(8'h93);
        chk(present_count[7], 16'h0000);
        cmd(3'h7, 1'b1, 1'b0, 1'b1);
        chk(present_count[7], 16'h0003);
        edges(2);
        chk(present_count[7], 16'h0001);
        fs.pulse(7, 2);
        wait_start(8'h93);
        chk(present_count[7], 16'h0003);
        $display("counter mode test done");
        close_out();
    end
endmodule
